// ==== pkg/uhc_pkg.sv ====
// constants for the host controller command and interrupt-status block
`default_nettype none
package uhc_pkg;
	// command codes on the microprocessor port; bit 7 marks a write
	localparam logic [7:0]  CODE_CMD_RD   = 8'h02;
	localparam logic [7:0]  CODE_CMD_WR   = 8'h82;
	localparam logic [7:0]  CODE_STAT_RD  = 8'h03;
	localparam logic [7:0]  CODE_STAT_WR  = 8'h83;
	localparam logic [7:0]  CODE_GATE_RD  = 8'h04;
	localparam logic [7:0]  CODE_GATE_WR  = 8'h84;
	localparam logic [7:0]  CODE_UNGATE_RD = 8'h05;
	localparam logic [7:0]  CODE_UNGATE_WR = 8'h85;

	// host_command_flags fields
	localparam int          CMD_SRST_BIT  = 0;
	localparam int          CMD_OVC_LSB   = 16;
	localparam logic [1:0]  OVC_RESET     = 2'h0;

	// interrupt_event_flags / interrupt_event_gates fields
	localparam int          EV_OVERRUN    = 0;
	localparam int          EV_FRAME      = 2;
	localparam int          EV_RESUME     = 3;
	localparam int          EV_FATAL      = 4;
	localparam int          EV_WRAP       = 5;
	localparam int          EV_PORT       = 6;
	localparam int          GATE_GLOBAL   = 31;
	localparam logic [31:0] EV_MASK       = 32'h0000007d;
	localparam logic [31:0] GATE_MASK     = 32'h8000007d;
	localparam logic [31:0] FLAGS_RESET   = 32'h00000000;
	localparam logic [31:0] GATES_RESET   = 32'h00000000;

	// soft reset timing
	localparam int          CLK_PERIOD_PS = 8000;
	localparam int          SRST_MAX_US   = 10;
	localparam int          SRST_MAX_CYC  = (SRST_MAX_US * 1000000) / CLK_PERIOD_PS;
	localparam int          SRST_CYC_DEF  = 16;

	typedef enum logic [1:0] {
		UHC_RUN   = 2'b01,
		UHC_SRST  = 2'b10
	} uhc_state_e;
endpackage : uhc_pkg
`default_nettype wire

// ==== hw/uhc_cmd_irq.sv ====
// command register, event flags, gates and interrupt request of the host controller
//
// Behaviour
// - two-bit overrun counter starts at zero, counts each overrun, wraps three to zero.
// - counter advances on every overrun even when the overrun flag is already set.
// - writing one to bit 0 forces bus suspend and resets operational registers.
// - hardware clears the soft reset bit when done, within 10 us.
// - soft reset leaves the root hub alone and drives no port reset.
// - no host bus accesses while the soft reset state lasts.
// - events set flags; software clears by writing one, never sets.
// - controller logic only sets flags; it clears them itself only on soft reset entry.
// - interrupt requested when flag, its gate and global gate are all set.
// - each gate bit except the global bit 31 gates only the flag in the same position.
// - bit 6 set when hub state or either port state changes.
// - bit 5 set when frame counter bit 15 toggles.
// - bit 4 flags a non-USB system error, halting processing until corrected.
// - fatal system error flag is held at zero here.
// - bit 3 set on device resume signaling, not on software resume entry.
// - each frame start emits a start-of-frame token and sets bit 2.
// - bit 0 set on schedule overrun, which also advances the counter.
// - command writes act on bit 0 only, a one starting soft reset; other bits ignored; reads normal.
// - overrun detected when periodic list unfinished at end of frame.
// - command register read with code 02 hex, written with 82 hex.
`default_nettype none
module uhc_cmd_irq #(
	parameter int SRST_CYCLES = uhc_pkg::SRST_CYC_DEF
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        acc_strobe,
	input  wire logic [7:0]  acc_code,
	input  wire logic [31:0] acc_wdata,
	output logic      [31:0] acc_rdata,
	output logic             acc_rvalid,
	input  wire logic        hub_state_changed,
	input  wire logic        port_state_changed,
	input  wire logic        frame_count_msb,
	input  wire logic        resume_signal,
	input  wire logic        sw_resume_active,
	input  wire logic        frame_start,
	input  wire logic        frame_end,
	input  wire logic        periodic_done,
	input  wire logic        bus_req,
	output logic             bus_req_ok,
	output logic             sof_token,
	output logic             soft_reset_active,
	output logic             force_bus_suspend,
	output logic             processing_halt,
	output logic             irq_req
);
	// ****************************************************************
	// parameter check
	// ****************************************************************
	if (SRST_CYCLES < 1 || SRST_CYCLES > uhc_pkg::SRST_MAX_CYC) begin : g_bad_srst
		$error("SRST_CYCLES out of range");
	end

	// ****************************************************************
	// access decode
	// ****************************************************************
	logic                  wr_cmd;
	logic                  wr_stat;
	logic                  wr_gate;
	logic                  wr_ungate;
	logic                  rd_any;
	uhc_pkg::uhc_state_e   state_q;
	logic [15:0]           srst_cnt_q;
	logic [31:0]           flags_q;
	logic [31:0]           gates_q;
	logic [1:0]            ovc_q;
	logic                  srst_start;
	logic                  srst_done;

	assign wr_cmd    = acc_strobe && acc_code == uhc_pkg::CODE_CMD_WR;
	assign wr_stat   = acc_strobe && acc_code == uhc_pkg::CODE_STAT_WR;
	assign wr_gate   = acc_strobe && acc_code == uhc_pkg::CODE_GATE_WR;
	assign wr_ungate = acc_strobe && acc_code == uhc_pkg::CODE_UNGATE_WR;
	assign rd_any    = acc_strobe && !acc_code[7];

	// ****************************************************************
	// soft reset sequencer
	// ****************************************************************
	// a second request during the reset is absorbed; the bit already reads one
	assign srst_start = wr_cmd && acc_wdata[uhc_pkg::CMD_SRST_BIT]
		&& state_q == uhc_pkg::UHC_RUN;
	assign srst_done  = state_q == uhc_pkg::UHC_SRST
		&& srst_cnt_q == 16'(SRST_CYCLES - 1);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_q    <= uhc_pkg::UHC_RUN;
			srst_cnt_q <= 16'h0000;
		end else begin
			case (state_q)
				uhc_pkg::UHC_RUN: begin
					srst_cnt_q <= 16'h0000;
					if (srst_start) begin
						state_q <= uhc_pkg::UHC_SRST;
					end
				end
				uhc_pkg::UHC_SRST: begin
					srst_cnt_q <= srst_cnt_q + 16'h0001;
					if (srst_done) begin
						state_q <= uhc_pkg::UHC_RUN;
					end
				end
				default: begin
					state_q    <= uhc_pkg::UHC_RUN;
					srst_cnt_q <= 16'h0000;
				end
			endcase
		end
	end

	// only the functional state and these registers are touched;
	// no root hub or downstream port reset leaves this block
	assign soft_reset_active = state_q == uhc_pkg::UHC_SRST;
	assign force_bus_suspend = state_q == uhc_pkg::UHC_SRST;
	assign bus_req_ok        = bus_req && state_q != uhc_pkg::UHC_SRST;

	// ****************************************************************
	// event detection
	// ****************************************************************
	logic        msb_q;
	logic        resume_q;
	logic        ev_overrun;
	logic [31:0] ev_set;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			msb_q    <= 1'b0;
			resume_q <= 1'b0;
		end else begin
			msb_q    <= frame_count_msb;
			resume_q <= resume_signal;
		end
	end

	assign ev_overrun = frame_end && !periodic_done;

	always_comb begin
		ev_set                       = 32'h00000000;
		ev_set[uhc_pkg::EV_OVERRUN]  = ev_overrun;
		ev_set[uhc_pkg::EV_FRAME]    = frame_start;
		ev_set[uhc_pkg::EV_RESUME]   = resume_signal && !resume_q
			&& !sw_resume_active;
		ev_set[uhc_pkg::EV_FATAL]    = 1'b0;
		ev_set[uhc_pkg::EV_WRAP]     = frame_count_msb != msb_q;
		ev_set[uhc_pkg::EV_PORT]     = hub_state_changed || port_state_changed;
	end

	// ****************************************************************
	// event flags, gates and overrun count
	// ****************************************************************
	// the set wins over a clear in the same cycle so no event is lost
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			flags_q <= uhc_pkg::FLAGS_RESET;
		end else if (srst_start) begin
			flags_q <= uhc_pkg::FLAGS_RESET;
		end else begin
			flags_q <= ((flags_q & ~(wr_stat ? acc_wdata : 32'h00000000))
				| ev_set) & uhc_pkg::EV_MASK;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			gates_q <= uhc_pkg::GATES_RESET;
		end else if (srst_start) begin
			gates_q <= uhc_pkg::GATES_RESET;
		end else if (wr_gate) begin
			gates_q <= gates_q | (acc_wdata & uhc_pkg::GATE_MASK);
		end else if (wr_ungate) begin
			gates_q <= gates_q & ~(acc_wdata & uhc_pkg::GATE_MASK);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ovc_q <= uhc_pkg::OVC_RESET;
		end else if (srst_start) begin
			ovc_q <= uhc_pkg::OVC_RESET;
		end else if (ev_overrun) begin
			ovc_q <= ovc_q + 2'h1;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq_req         <= 1'b0;
			sof_token       <= 1'b0;
			processing_halt <= 1'b0;
		end else begin
			irq_req         <= |(flags_q & gates_q & uhc_pkg::EV_MASK)
				&& gates_q[uhc_pkg::GATE_GLOBAL];
			sof_token       <= frame_start;
			processing_halt <= flags_q[uhc_pkg::EV_FATAL];
		end
	end

	// ****************************************************************
	// read path
	// ****************************************************************
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			acc_rdata  <= 32'h00000000;
			acc_rvalid <= 1'b0;
		end else begin
			acc_rvalid <= rd_any;
			if (rd_any) begin
				case (acc_code)
					uhc_pkg::CODE_CMD_RD: begin
						acc_rdata <= 32'h00000000;
						acc_rdata[uhc_pkg::CMD_OVC_LSB +: 2] <= ovc_q;
						acc_rdata[uhc_pkg::CMD_SRST_BIT]     <=
							state_q == uhc_pkg::UHC_SRST;
					end
					uhc_pkg::CODE_STAT_RD:   acc_rdata <= flags_q;
					uhc_pkg::CODE_GATE_RD:   acc_rdata <= gates_q;
					uhc_pkg::CODE_UNGATE_RD: acc_rdata <= gates_q;
					default:                 acc_rdata <= 32'h00000000;
				endcase
			end
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	logic [15:0] srst_len_q;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			srst_len_q <= 16'h0000;
		end else begin
			srst_len_q <= soft_reset_active ? srst_len_q + 16'h0001 : 16'h0000;
		end
	end

	a_ovc_wraps: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ev_overrun && !srst_start |=> ovc_q == $past(ovc_q) + 2'h1)
		else $error("overrun count did not advance");
	a_ovc_when_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ev_overrun && flags_q[0] && !srst_start |=> ovc_q != $past(ovc_q))
		else $error("overrun count stuck with flag set");
	a_srst_enter: assert property (@(posedge clk_sys) disable iff (!rst_n)
		srst_start |=> force_bus_suspend && flags_q == 32'h00000000)
		else $error("soft reset not entered");
	a_srst_bound: assert property (@(posedge clk_sys) disable iff (!rst_n)
		srst_len_q <= 16'(uhc_pkg::SRST_MAX_CYC))
		else $error("soft reset too long");
	a_srst_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
		soft_reset_active |-> !bus_req_ok)
		else $error("bus access during soft reset");
	a_flag_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
		wr_stat && acc_wdata[2] && !frame_start && !srst_start |=> !flags_q[2])
		else $error("flag not cleared by write of one");
	a_flag_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
		flags_q[5] && !wr_stat && !srst_start |=> flags_q[5])
		else $error("flag dropped without software");
	a_irq_req: assert property (@(posedge clk_sys) disable iff (!rst_n)
		flags_q[6] && gates_q[6] && gates_q[31] |=> irq_req)
		else $error("interrupt not raised");
	a_irq_gated: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!gates_q[31] |=> !irq_req)
		else $error("interrupt without global gate");
	a_wrap_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
		frame_count_msb != msb_q && !srst_start |=> flags_q[5])
		else $error("wrap flag missed");
	a_fatal_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!flags_q[4] && !processing_halt)
		else $error("fatal flag set");
	a_sof_pair: assert property (@(posedge clk_sys) disable iff (!rst_n)
		frame_start && !srst_start |=> sof_token && flags_q[2])
		else $error("frame start not reflected");
	// length is counted from the state itself, so a miscounted sequencer shows here
	a_srst_length: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$fell(soft_reset_active) |-> srst_len_q == 16'(SRST_CYCLES))
		else $error("soft reset length wrong");
	a_bus_pass: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!soft_reset_active |-> bus_req_ok == bus_req)
		else $error("bus grant wrong outside soft reset");
	a_port_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(hub_state_changed || port_state_changed) && !srst_start |=> flags_q[6])
		else $error("port change flag missed");
	a_resume_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
		resume_signal && !resume_q && !sw_resume_active && !srst_start |=> flags_q[3])
		else $error("resume flag missed");
	a_resume_sw: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!flags_q[3] && (sw_resume_active || !resume_signal || resume_q) |=> !flags_q[3])
		else $error("resume flag set without device resume");
	a_no_sw_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
		wr_stat && !flags_q[6] && !hub_state_changed && !port_state_changed |=> !flags_q[6])
		else $error("software write set a flag");
	a_ovc_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!ev_overrun && !srst_start |=> $stable(ovc_q))
		else $error("overrun count moved without overrun");
	a_read_answer: assert property (@(posedge clk_sys) disable iff (!rst_n)
		rd_any |=> acc_rvalid)
		else $error("read not answered");
endmodule // uhc_cmd_irq
`default_nettype wire

// ==== bench/uhc_host_model.sv ====
// host processor model issuing command-port accesses
`default_nettype none
module uhc_host_model (
	input  wire logic        clk_sys,
	input  wire logic [31:0] acc_rdata,
	input  wire logic        acc_rvalid,
	output var  logic        acc_strobe,
	output var  logic [7:0]  acc_code,
	output var  logic [31:0] acc_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		acc_strobe = 1'b0;
		acc_code = 8'h00;
		acc_wdata = 32'h00000000;
	end
	// ************
	// access tasks
	// ************
	// released data shows the inverse so a stale word is never mistaken for fresh
	task automatic wr(input logic [7:0] code, input logic [31:0] d);
		@(posedge clk_sys);
		acc_strobe <= 1'b1;
		acc_code <= code;
		acc_wdata <= d;
		@(posedge clk_sys);
		acc_strobe <= 1'b0;
		acc_wdata <= ~d;
	endtask
	task automatic rd(input logic [7:0] code, output logic [31:0] q, output logic ok);
		int n;
		@(posedge clk_sys);
		acc_strobe <= 1'b1;
		acc_code <= code;
		@(posedge clk_sys);
		acc_strobe <= 1'b0;
		ok = 1'b0;
		q = 32'h00000000;
		for (n = 0; n < 4 && !ok; n++) begin
			@(posedge clk_sys);
			if (acc_rvalid === 1'b1) begin
				ok = 1'b1;
				q = acc_rdata;
			end
		end
	endtask
endmodule // uhc_host_model
`default_nettype wire

// ==== bench/uhc_cmd_irq_tb.sv ====
// self-checking bench for the command and interrupt-status block
`default_nettype none
module uhc_cmd_irq_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SRST = 2;
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic [3:0]  pls = 4'h0;
	logic        fmsb = 1'b0;
	logic        res = 1'b0;
	logic        swres = 1'b0;
	logic        pdone = 1'b1;
	logic        bus_req = 1'b0;
	logic        stb;
	logic [7:0]  code;
	logic [31:0] wd;
	logic [31:0] rdat;
	logic        rv;
	logic        bus_req_ok;
	logic        sof_token;
	logic        soft_reset_active;
	logic        force_bus_suspend;
	logic        processing_halt;
	logic        irq_req;
	int          err_total = 0;
	int          n_checks = 0;
	int          cyc = 0;
	int          sofs = 0;
	int          n;
	always #4 clk_sys = ~clk_sys;
	uhc_host_model host (.clk_sys(clk_sys), .acc_rdata(rdat), .acc_rvalid(rv),
		.acc_strobe(stb), .acc_code(code), .acc_wdata(wd));
	uhc_cmd_irq #(.SRST_CYCLES(SRST)) uut (.clk_sys(clk_sys), .rst_n(rst_n),
		.acc_strobe(stb), .acc_code(code), .acc_wdata(wd), .acc_rdata(rdat),
		.acc_rvalid(rv), .hub_state_changed(pls[0]), .port_state_changed(pls[1]),
		.frame_count_msb(fmsb), .resume_signal(res), .sw_resume_active(swres),
		.frame_start(pls[2]), .frame_end(pls[3]), .periodic_done(pdone),
		.bus_req(bus_req), .bus_req_ok(bus_req_ok), .sof_token(sof_token),
		.soft_reset_active(soft_reset_active), .force_bus_suspend(force_bus_suspend),
		.processing_halt(processing_halt), .irq_req(irq_req));
	// ***********
	// bench tasks
	// ***********
	task automatic test_done;
		if (err_total == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rchk(input string nm, input logic [7:0] c, input logic [31:0] e);
		logic [31:0] q;
		logic ok;
		host.rd(c, q, ok);
		chk({nm, "_valid"}, 32'h1, {31'h0, ok});
		chk(nm, e, q);
	endtask
	task automatic pulse(input int i);
		@(posedge clk_sys) pls[i] <= 1'b1;
		@(posedge clk_sys) pls[i] <= 1'b0;
	endtask
	task automatic irq_is(input logic e);
		repeat (3) @(posedge clk_sys);
		chk("irq_req", {31'h0, e}, {31'h0, irq_req});
	endtask
	always @(posedge clk_sys) begin
		if (sof_token === 1'b1) sofs <= sofs + 1;
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_total++;
			test_done;
		end
	end
	// **********
	// test steps
	// **********
	initial begin
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		rchk("cmd_rst", uhc_pkg::CODE_CMD_RD, 32'h0);
		rchk("stat_rst", uhc_pkg::CODE_STAT_RD, 32'h0);
		rchk("unmapped", 8'h10, 32'h0);
		pulse(3);
		rchk("no_overrun", uhc_pkg::CODE_CMD_RD, 32'h0);
		@(posedge clk_sys) pdone <= 1'b0;
		for (int i = 1; i <= 5; i++) begin
			pulse(3);
			rchk("ovr_count", uhc_pkg::CODE_CMD_RD, 32'(i & 3) << 16);
		end
		pulse(2);
		pulse(0);
		@(posedge clk_sys) fmsb <= 1'b1;
		swres <= 1'b1;
		res <= 1'b1;
		@(posedge clk_sys) res <= 1'b0;
		swres <= 1'b0;
		rchk("events", uhc_pkg::CODE_STAT_RD, 32'h65);
		@(posedge clk_sys) res <= 1'b1;
		rchk("resume", uhc_pkg::CODE_STAT_RD, 32'h6d);
		host.wr(uhc_pkg::CODE_STAT_WR, 32'h40);
		rchk("clr_one", uhc_pkg::CODE_STAT_RD, 32'h2d);
		pulse(1);
		host.wr(uhc_pkg::CODE_STAT_WR, 32'h0);
		rchk("port_chg", uhc_pkg::CODE_STAT_RD, 32'h6d);
		host.wr(uhc_pkg::CODE_GATE_WR, 32'h80000008);
		irq_is(1'b1);
		host.wr(uhc_pkg::CODE_UNGATE_WR, 32'h80000000);
		irq_is(1'b0);
		host.wr(uhc_pkg::CODE_UNGATE_WR, 32'h8);
		host.wr(uhc_pkg::CODE_GATE_WR, 32'h80000010);
		irq_is(1'b0);
		rchk("gates", uhc_pkg::CODE_UNGATE_RD, 32'h80000010);
		host.wr(uhc_pkg::CODE_STAT_WR, 32'hffffffff);
		host.wr(uhc_pkg::CODE_STAT_WR, 32'h7d);
		rchk("clr_all", uhc_pkg::CODE_STAT_RD, 32'h0);
		chk("halt", 32'h0, {31'h0, processing_halt});
		host.wr(uhc_pkg::CODE_CMD_WR, 32'hfffffffe);
		rchk("cmd_ro", uhc_pkg::CODE_CMD_RD, 32'h00010000);
		pulse(2);
		@(posedge clk_sys) bus_req <= 1'b1;
		host.wr(uhc_pkg::CODE_CMD_WR, 32'h1);
		#1;
		chk("srst_act", 32'h1, {31'h0, soft_reset_active});
		chk("suspend", 32'h1, {31'h0, force_bus_suspend});
		chk("bus_ok", 32'h0, {31'h0, bus_req_ok});
		n = 0;
		while (soft_reset_active !== 1'b0 && n < uhc_pkg::SRST_MAX_CYC) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		chk("srst_len", 32'(SRST), 32'(n));
		chk("suspend_after", 32'h0, {31'h0, force_bus_suspend});
		#1;
		chk("bus_ok_after", 32'h1, {31'h0, bus_req_ok});
		rchk("cmd_after", uhc_pkg::CODE_CMD_RD, 32'h0);
		rchk("gates_after", uhc_pkg::CODE_GATE_RD, 32'h0);
		host.wr(uhc_pkg::CODE_STAT_WR, 32'h10);
		rchk("stat_after", uhc_pkg::CODE_STAT_RD, 32'h0);
		chk("sof_count", 32'h2, 32'(sofs));
		test_done;
	end
endmodule // uhc_cmd_irq_tb
`default_nettype wire
